// ### rtl/pmtr_consts.vh
`ifndef PMTR_CONSTS_VH
`define PMTR_CONSTS_VH
// register byte addresses on the wishbone bus
`define PMTR_ADDR_PTR_LOW 5'h00
`define PMTR_ADDR_PTR_HIGH 5'h04
`define PMTR_ADDR_PTR_UPPER 5'h08
`define PMTR_ADDR_LATCH 5'h0C
// command register: write starts an instruction, read shows status
`define PMTR_ADDR_CMD 5'h10
`define PMTR_ADDR_BITS 5
// command codes
`define PMTR_CMD_NO_UPDATE 3'h0
`define PMTR_CMD_POST_INC 3'h1
`define PMTR_CMD_POST_DEC 3'h2
`define PMTR_CMD_PRE_INC 3'h3
`define PMTR_CMD_STORE 3'h4
// pointer layout
`define PMTR_PTR_BITS 22
`define PMTR_SPACE_BIT 21
`define PMTR_UPPER_BITS 6
`define PMTR_STEP 21'h000001
// store instruction length in cycles
`define PMTR_STORE_CYCLES 2'h2
`define PMTR_RESET_BYTE 8'h00
`define PMTR_RESET_PTR 22'h000000
`endif

// ### rtl/pmtr_table_read.v
// Operation
// - each fetch loads exactly one byte
// - eight-bit latch holds the moved byte
// - pointer is upper six, high, low bytes
// - low 21 bits program, bit 21 configuration
// - none, post-inc, post-dec, pre-inc treatments
// - updates touch only low 21 bits
// - all 22 bits select fetched byte
// - pointer bit zero picks word byte
// - fetches allowed at any byte address
// - store instruction: two cycles, no effect
// - upper byte unused bits read zero
// - program memory never written here
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pmtr_consts.vh"
module pmtr_table_read #(
	parameter WORD_BITS = 16
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [`PMTR_ADDR_BITS-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// program memory read port, word addressed
	output reg [`PMTR_PTR_BITS-2:0] mem_word_addr,
	output reg mem_config_space,
	output reg mem_rd,
	input wire [WORD_BITS-1:0] mem_word,
	input wire mem_valid,
	// instruction status
	output reg busy
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_FETCH = 4'b0010;
	localparam ST_WAIT = 4'b0100;
	localparam ST_STORE = 4'b1000;

	reg [3:0] state;
	reg [`PMTR_PTR_BITS-1:0] pointer;
	reg [7:0] latch;
	reg [2:0] cmd;
	reg [1:0] store_count;
	reg byte_sel;
	reg [31:0] next_rdata;
	wire access;
	wire wr;
	wire [20:0] ptr_inc;
	wire [20:0] ptr_dec;

	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = access & wb_we_i & wb_sel_i[0];
	// carry into bit 21 dropped on purpose
	assign ptr_inc = pointer[20:0] + `PMTR_STEP;
	assign ptr_dec = pointer[20:0] - `PMTR_STEP;

	always @* begin
		next_rdata = 32'h00000000;
		case (wb_adr_i)
			`PMTR_ADDR_PTR_LOW: next_rdata[7:0] = pointer[7:0];
			`PMTR_ADDR_PTR_HIGH: next_rdata[7:0] = pointer[15:8];
			// top two bits read zero
			`PMTR_ADDR_PTR_UPPER: next_rdata[`PMTR_UPPER_BITS-1:0] = pointer[21:16];
			`PMTR_ADDR_LATCH: next_rdata[7:0] = latch;
			`PMTR_ADDR_CMD: next_rdata[0] = busy;
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
			pointer <= `PMTR_RESET_PTR;
			latch <= `PMTR_RESET_BYTE;
			cmd <= `PMTR_CMD_NO_UPDATE;
			store_count <= 2'h0;
			byte_sel <= 1'b0;
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
			mem_word_addr <= 21'h000000;
			mem_config_space <= 1'b0;
			mem_rd <= 1'b0;
			busy <= 1'b0;
		end else begin
			wb_ack_o <= access;
			if (access)
				wb_dat_o <= next_rdata;
			mem_rd <= 1'b0;
			case (state)
				ST_IDLE: begin
					// register writes only accepted while idle
					if (wr) begin
						case (wb_adr_i)
							`PMTR_ADDR_PTR_LOW: pointer[7:0] <= wb_dat_i[7:0];
							`PMTR_ADDR_PTR_HIGH: pointer[15:8] <= wb_dat_i[7:0];
							`PMTR_ADDR_PTR_UPPER: pointer[21:16] <= wb_dat_i[5:0];
							`PMTR_ADDR_LATCH: latch <= wb_dat_i[7:0];
							`PMTR_ADDR_CMD: begin
								cmd <= wb_dat_i[2:0];
								busy <= 1'b1;
								if (wb_dat_i[2:0] == `PMTR_CMD_STORE) begin
									store_count <= `PMTR_STORE_CYCLES;
									state <= ST_STORE;
								end else begin
									state <= ST_FETCH;
								end
							end
							default: begin
							end
						endcase
					end
				end
				ST_FETCH: begin
					// pre-increment updates first, read uses new value
					if (cmd == `PMTR_CMD_PRE_INC) begin
						pointer[20:0] <= ptr_inc;
						mem_word_addr <= {pointer[21], ptr_inc[20:1]};
						byte_sel <= ptr_inc[0];
					end else begin
						mem_word_addr <= pointer[21:1];
						byte_sel <= pointer[0];
					end
					mem_config_space <= pointer[`PMTR_SPACE_BIT];
					mem_rd <= 1'b1;
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (mem_valid) begin
						// one byte only; high byte when bit zero is set
						latch <= byte_sel ? mem_word[15:8] : mem_word[7:0];
						if (cmd == `PMTR_CMD_POST_INC)
							pointer[20:0] <= ptr_inc;
						else if (cmd == `PMTR_CMD_POST_DEC)
							pointer[20:0] <= ptr_dec;
						busy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_STORE: begin
					// no write path exists to program memory
					if (store_count == 2'h1) begin
						busy <= 1'b0;
						state <= ST_IDLE;
					end
					store_count <= store_count - 2'h1;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### bench/pmtr_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pmtr_mem (
	// word port
	input wire logic clk, rd,
	input wire logic [20:0] addr,
	output logic [15:0] word = 16'h0000,
	output logic valid = 1'b0
);
	// stale word inverted each cycle, so it differs from the last fresh word only on every other cycle after valid
	always @(posedge clk) begin
		valid <= rd;
		word <= rd ? {addr[20], addr[6:0], addr[7:0] ^ 8'h5A} : ~word;
	end
endmodule
`default_nettype wire

// ### bench/pmtr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pmtr_checker (
	// design ports
	input wire logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [4:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i, wb_dat_o,
	input wire logic [20:0] mem_word_addr,
	input wire logic mem_config_space, mem_rd, mem_valid, busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_go;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy && wb_adr_i == 5'h10;
	endsequence
	AST_FETCH: assert property (s_go and wb_dat_i[2:0] != 3'h4 |-> ##2 mem_rd)
		else $error("fetch");
	AST_STORE: assert property (s_go and wb_dat_i[2:0] == 3'h4 |=>
		!mem_rd throughout (busy ##1 busy ##1 !busy)) else $error("store");
	AST_ONE: assert property (mem_rd |=> !mem_rd) else $error("rd");
	AST_BUSY: assert property (mem_rd |-> busy) else $error("busy");
	AST_DONE: assert property (busy && mem_valid && !mem_rd |-> ##[1:2] !busy)
		else $error("done");
	AST_SPACE: assert property (mem_rd |-> mem_word_addr[20] == mem_config_space)
		else $error("cfg");
	AST_HI: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("hi");
	AST_UP: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h08 |-> wb_dat_o[7:6] == 2'h0)
		else $error("up");
endmodule
bind pmtr_table_read pmtr_checker u_chk (.*);
`default_nettype wire

// ### bench/test_pmtr_table_read.sv
`timescale 1ns/1ps
`default_nettype none
module test_pmtr_table_read;
	logic clk = 0, reset = 1, cyc = 0, we = 0, ack, rd, val;
	logic [4:0] adr = 5'h00;
	logic [31:0] dat = 32'h0, rdat, q;
	logic [20:0] wa;
	logic [15:0] w;
	logic [21:0] p = 22'h3FFFFF;
	logic [7:0] e = 8'hC3;
	logic [2:0] seq [8] = '{1, 2, 3, 4, 0, 2, 7, 5};
	int n_fail = 0, comparisons = 0;
	always #20 clk = ~clk;
	pmtr_table_read u_dut(.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.mem_word_addr(wa), .mem_config_space(), .mem_rd(rd), .mem_word(w), .mem_valid(val),
		.busy());
	pmtr_mem u_mem(.clk(clk), .rd(rd), .addr(wa), .word(w), .valid(val));
	task chk(input [7:0] g, x);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("ERROR %0t %h/%h", $time, g, x);
		end
	endtask
	task bus(input [4:0] a, input wr, input [7:0] d);
		@(posedge clk);
		{cyc, we, adr, dat} <= {1'b1, wr, a, 24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
	endtask
	task rc(input [4:0] a, input [7:0] x);
		bus(a, 0, 8'h00);
		chk(q[7:0], x);
	endtask
	task run(input [2:0] c);
		bus(5'h10, 1, {5'h00, c});
		do bus(5'h10, 0, 8'h00); while (q[0]);
		if (c == 3) p[20:0] += 1;
		if (c != 4) e = p[0] ? {p[21], p[7:1]} : p[8:1] ^ 8'h5A;
		if (c == 1) p[20:0] += 1;
		if (c == 2) p[20:0] -= 1;
		rc(5'h0C, e);
		rc(5'h00, p[7:0]);
		rc(5'h04, p[15:8]);
		rc(5'h08, {2'h0, p[21:16]});
	endtask
	task give_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset <= 0;
		bus(5'h0C, 1, e);
		rc(5'h0C, e);
		bus(5'h08, 1, 8'hFF);
		rc(5'h08, 8'h3F);
		bus(5'h04, 1, 8'hFF);
		bus(5'h00, 1, 8'hFF);
		foreach (seq[i]) run(seq[i]);
		bus(5'h08, 1, 8'h00);
		p[21:16] = 6'h00;
		run(3);
		rc(5'h14, 8'h00);
		give_verdict;
	end
	// a few hundred cycles of traffic, so this only trips on a hang
	initial begin
		#100000;
		n_fail++;
		give_verdict;
	end
endmodule
`default_nettype wire
